// file: dcmd_pkg.sv
// Constants, encodings and timing for the direct command executor
package dcmd_pkg;
	// Clock rate
	localparam int CLK_HZ      = 20_000_000;
	// Command codes
	localparam logic [7:0] CMD_MASK_RX   = 8'h01;
	localparam logic [7:0] CMD_UNMASK_RX = 8'h02;
	localparam logic [7:0] CMD_MEAS_AMP  = 8'h03;
	localparam logic [7:0] CMD_SQUELCH   = 8'h04;
	localparam logic [7:0] CMD_RST_GAIN  = 8'h05;
	localparam logic [7:0] CMD_ADJ_REG   = 8'h06;
	localparam logic [7:0] CMD_CAL_MOD   = 8'h07;
	localparam logic [7:0] CMD_CAL_ANT   = 8'h08;
	localparam logic [7:0] CMD_MEAS_PH   = 8'h09;
	localparam logic [7:0] CMD_CLR_RSSI  = 8'h0a;
	localparam logic [7:0] CMD_TRANSP    = 8'h0b;
	localparam logic [7:0] CMD_MEAS_SUP  = 8'h0c;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_CMD    = 8'h04;
	localparam logic [7:0] OFF_STAT   = 8'h08;
	localparam logic [7:0] OFF_ADC    = 8'h0c;
	localparam logic [7:0] OFF_RSSI   = 8'h10;
	localparam logic [7:0] OFF_MOD    = 8'h14;
	localparam logic [7:0] OFF_RXCF4  = 8'h18;
	localparam logic [7:0] OFF_REGSET = 8'h1c;
	localparam logic [7:0] OFF_TRIM   = 8'h20;
	// Control register fields
	localparam int CTL_RX_EN  = 0;
	localparam int CTL_TX_EN  = 1;
	localparam int CTL_REG_S  = 2;
	localparam int CTL_SUP_LO = 3;
	localparam int CTL_SUP_HI = 4;
	localparam int CTL_3V3    = 5;
	localparam int CTL_EN     = 7;
	localparam logic [7:0] CTL_RST = 8'h00;
	// Status register fields
	localparam int STA_BUSY = 0;
	localparam int STA_RXON = 1;
	localparam int STA_TRSP = 2;
	localparam int STA_TERM = 3;
	localparam int STA_SQL  = 4;
	// Converter mux selections
	localparam logic [1:0] MUX_AMP = 2'h0;
	localparam logic [1:0] MUX_PH  = 2'h1;
	localparam logic [1:0] MUX_SUP = 2'h2;
	// Regulator ranges in mV
	localparam int REG5_MAX_MV = 5100;
	localparam int REG5_MIN_MV = 3900;
	localparam int REG5_STEP_MV = 120;
	localparam int REG3_MAX_MV = 3400;
	localparam int REG3_MIN_MV = 2400;
	localparam int REG3_STEP_MV = 100;
	localparam logic [3:0] REG5_TOP = 4'((REG5_MAX_MV - REG5_MIN_MV) / REG5_STEP_MV);
	localparam logic [3:0] REG3_TOP = 4'((REG3_MAX_MV - REG3_MIN_MV) / REG3_STEP_MV);
	// Timing in microseconds and derived cycle counts
	localparam int MEAS_US = 25;
	localparam int MEAS_CYC = (MEAS_US * (CLK_HZ / 1_000_000) > 0) ?
		MEAS_US * (CLK_HZ / 1_000_000) : 1;
	localparam int SQL_US = 500;
	localparam int REGW_US = 300;
	localparam int REGT_US = 5000;
	localparam int MOD_US = 275;
	localparam int ANT_US = 250;
	localparam int SQL_STEP_US = 25;
	localparam int CYC_PER_US = CLK_HZ / 1_000_000;
	localparam logic [7:0] PHASE_MID = 8'h80;
endpackage : dcmd_pkg

// file: reader_direct_command_exec.sv
// Direct command executor with APB register access
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module reader_direct_command_exec
	import dcmd_pkg::*;
#(
	parameter int SQL_CYC  = SQL_US * CYC_PER_US,
	parameter int REGW_CYC = REGW_US * CYC_PER_US,
	parameter int REGT_CYC = REGT_US * CYC_PER_US,
	parameter int MOD_CYC  = MOD_US * CYC_PER_US,
	parameter int ANT_CYC  = ANT_US * CYC_PER_US,
	parameter int SQLS_CYC = SQL_STEP_US * CYC_PER_US
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Pins and analog status from outside the clock domain
	input  wire logic        ss_n,
	input  wire logic        osc_stable,
	input  wire logic        reg_margin_ok,
	input  wire logic        noise_detect,
	input  wire logic        mask_timer_running,
	// Converter and receiver, same clock
	input  wire logic        adc_done,
	input  wire logic [7:0]  adc_data,
	input  wire logic [5:0]  rssi_level,
	// Analog controls
	output logic             rx_on,
	output logic             framing_en,
	output logic             tx_force,
	output logic             rx_force,
	output logic             amp_det_en,
	output logic             phase_det_en,
	output logic             supply_div_en,
	output logic [1:0]       supply_sel,
	output logic             adc_start,
	output logic             adc_relative,
	output logic [1:0]       adc_mux,
	output logic [3:0]       reg_setting,
	output logic             squelch_run,
	output logic [3:0]       squelch_gain,
	output logic [3:0]       gain_reduction,
	output logic [7:0]       mod_drive,
	output logic [7:0]       trim_capacitor_pins,
	output logic             transparent,
	output logic             mask_timer_clr,
	output logic             term_pulse
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_MEAS = 3'b001,
		ST_CAL  = 3'b011,
		ST_REG  = 3'b010,
		ST_SQL  = 3'b110
	} state_e;

	// Two-flop synchronisers for the outside inputs
	logic [4:0] sync1_r;
	logic [4:0] sync2_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r <= 5'h1f;
			sync2_r <= 5'h1f;
		end else begin
			sync1_r <= {ss_n, osc_stable, reg_margin_ok, noise_detect, mask_timer_running};
			sync2_r <= sync1_r;
		end
	end
	wire ss_s     = sync2_r[4];
	wire osc_s    = sync2_r[3];
	wire margin_s = sync2_r[2];
	wire noise_s  = sync2_r[1];
	wire mtmr_s   = sync2_r[0];

	// Registers and state
	state_e      st_r;
	state_e      st_nxt;
	logic [7:0]  ctrl_r;
	logic [7:0]  mod_tgt_r;
	logic [3:0]  rxcf4_r;
	logic [7:0]  adc_r;
	logic [5:0]  rssi_r;
	logic        rx_on_r;
	logic        rx_on_d_r;
	logic        term_flag_r;
	logic        armed_r;
	logic        ss_d_r;
	logic        trsp_r;
	logic [7:0]  cmd_r;
	logic        go_r;
	logic [16:0] tmr_r;
	logic [16:0] tot_r;
	logic        adc_wait_r;
	logic        is_ant_r;
	logic [3:0]  regset_r;
	logic [3:0]  sqlg_r;
	logic [3:0]  gain_r;
	logic [7:0]  drive_r;
	logic [7:0]  trim_r;
	logic [1:0]  mux_r;
	logic        last_up_r;

	// APB decode
	wire wr       = psel && penable && pwrite;
	wire rd_ok    = (paddr <= OFF_TRIM) && (paddr[1:0] == 2'h0); // Word map has no holes
	wire wr_ctrl  = wr && (paddr == OFF_CTRL);
	wire wr_cmd   = wr && (paddr == OFF_CMD);
	wire wr_stat  = wr && (paddr == OFF_STAT);
	wire wr_mod   = wr && (paddr == OFF_MOD);
	wire wr_rxcf4 = wr && (paddr == OFF_RXCF4);
	wire busy     = (st_r != ST_IDLE);
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !rd_ok;

	// Read mux
	wire [7:0] stat_v = {3'h0, squelch_run, term_flag_r, trsp_r, rx_on_r, busy};
	always_comb begin
		prdata = 32'h0;
		if (psel && !pwrite) begin
			unique case (paddr)
				OFF_CTRL:   prdata = {24'h0, ctrl_r};
				OFF_STAT:   prdata = {24'h0, stat_v};
				OFF_ADC:    prdata = {24'h0, adc_r};
				OFF_RSSI:   prdata = {26'h0, rssi_r};
				OFF_MOD:    prdata = {16'h0, drive_r, mod_tgt_r};
				OFF_RXCF4:  prdata = {28'h0, rxcf4_r};
				OFF_REGSET: prdata = {28'h0, regset_r};
				OFF_TRIM:   prdata = {24'h0, trim_r};
				default:    prdata = 32'h0;
			endcase
		end
	end

	// Acceptance conditions for the incoming code
	wire [7:0] wc   = pwdata[7:0];
	wire en_ok      = ctrl_r[CTL_EN] && osc_s;
	wire rx_ok      = ctrl_r[CTL_RX_EN];
	wire trx_ok     = ctrl_r[CTL_RX_EN] && ctrl_r[CTL_TX_EN];
	wire reg_ok     = en_ok && !ctrl_r[CTL_REG_S];
	wire is_mask    = (wc == CMD_MASK_RX) || (wc == CMD_UNMASK_RX);
	wire is_en_cmd  = (wc == CMD_MEAS_AMP) || (wc == CMD_MEAS_PH) || (wc == CMD_MEAS_SUP) ||
		(wc == CMD_CAL_MOD) || (wc == CMD_CAL_ANT) || (wc == CMD_RST_GAIN) ||
		(wc == CMD_CLR_RSSI) || (wc == CMD_TRANSP);
	wire sql_abort  = (st_r == ST_SQL) && (wc == CMD_RST_GAIN);
	wire accept     = wr_cmd && (!busy || sql_abort) &&
		((is_mask && rx_ok) || (is_en_cmd && en_ok) ||
		((wc == CMD_ADJ_REG) && reg_ok) ||
		((wc == CMD_SQUELCH) && trx_ok));
	wire c_mask   = go_r && (cmd_r == CMD_MASK_RX);
	wire c_unmask = go_r && (cmd_r == CMD_UNMASK_RX);
	wire c_rgain  = go_r && (cmd_r == CMD_RST_GAIN);
	wire c_crssi  = go_r && (cmd_r == CMD_CLR_RSSI);
	wire c_trsp   = go_r && (cmd_r == CMD_TRANSP);
	wire c_meas   = go_r && ((cmd_r == CMD_MEAS_AMP) || (cmd_r == CMD_MEAS_PH) ||
		(cmd_r == CMD_MEAS_SUP));
	wire c_cal    = go_r && ((cmd_r == CMD_CAL_MOD) || (cmd_r == CMD_CAL_ANT));
	wire c_reg    = go_r && (cmd_r == CMD_ADJ_REG);
	wire c_sql    = go_r && (cmd_r == CMD_SQUELCH) && !rx_on_r;
	wire [3:0] reg_top = ctrl_r[CTL_3V3] ? REG3_TOP : REG5_TOP;

	// Limits of the timed sequences
	wire [16:0] cal_lim  = is_ant_r ? 17'(ANT_CYC) : 17'(MOD_CYC);
	wire meas_to  = (tmr_r >= 17'(MEAS_CYC - 1));
	wire cal_to   = (tot_r >= cal_lim - 17'h1);
	wire reg_tick = (tmr_r >= 17'(REGW_CYC - 1));
	wire reg_to   = (tot_r >= 17'(REGT_CYC - 1));
	wire sql_to   = (tot_r >= 17'(SQL_CYC - 1));
	wire sql_tick = (tmr_r >= 17'(SQLS_CYC - 1));
	wire adc_got  = adc_wait_r && adc_done;

	// Calibration compare: modulation uses target, antenna seeks mid scale
	wire [7:0] cal_ref = is_ant_r ? PHASE_MID : mod_tgt_r;
	wire cal_hit  = adc_got && (adc_data == cal_ref);
	wire cal_up   = adc_data < cal_ref;
	wire cal_flip = adc_got && (cal_up != last_up_r) && (tot_r > tmr_r);
	wire reg_done = reg_tick && (margin_s || (regset_r == 4'h0));

	// Next state
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			ST_IDLE: begin
				if (c_meas)
					st_nxt = ST_MEAS;
				else if (c_cal)
					st_nxt = ST_CAL;
				else if (c_reg)
					st_nxt = ST_REG;
				else if (c_sql)
					st_nxt = ST_SQL;
			end
			ST_MEAS: if (adc_got || meas_to) st_nxt = ST_IDLE;
			ST_CAL:  if (cal_hit || cal_flip || cal_to) st_nxt = ST_IDLE;
			ST_REG:  if (reg_done || reg_to) st_nxt = ST_IDLE;
			ST_SQL:  if (!noise_s || sql_to || c_rgain) st_nxt = ST_IDLE;
		endcase
	end

	// Ending of a sequence that reports termination
	wire term = busy && (st_nxt == ST_IDLE) && (st_r != ST_SQL);

	// Sequencer state, timers and command latch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r  <= ST_IDLE;
			cmd_r <= 8'h00;
			go_r  <= 1'b0;
			tmr_r <= 17'h0;
			tot_r <= 17'h0;
		end else begin
			st_r <= st_nxt;
			go_r <= accept;
			if (accept)
				cmd_r <= wc;
			if (st_nxt != st_r || (st_r == ST_REG && reg_tick) ||
				(st_r == ST_SQL && sql_tick) || adc_got)
				tmr_r <= 17'h0;
			else
				tmr_r <= tmr_r + 17'h1;
			tot_r <= (st_nxt != st_r) ? 17'h0 : tot_r + 17'h1;
		end
	end

	// Converter requests and mux selection
	wire adc_go = (c_meas || c_cal) ||
		(st_r == ST_CAL && adc_got && st_nxt == ST_CAL);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adc_wait_r <= 1'b0;
			mux_r      <= MUX_AMP;
			is_ant_r   <= 1'b0;
			last_up_r  <= 1'b0;
			adc_r      <= 8'h00;
		end else begin
			if (adc_go)
				adc_wait_r <= 1'b1;
			else if (adc_got || !busy)
				adc_wait_r <= 1'b0;
			if (c_meas)
				mux_r <= (cmd_r == CMD_MEAS_PH) ? MUX_PH :
					(cmd_r == CMD_MEAS_SUP) ? MUX_SUP : MUX_AMP;
			else if (c_cal)
				mux_r <= (cmd_r == CMD_CAL_ANT) ? MUX_PH : MUX_AMP;
			if (c_cal)
				is_ant_r <= (cmd_r == CMD_CAL_ANT);
			if (adc_got)
				last_up_r <= cal_up;
			if (adc_got && st_r == ST_MEAS)
				adc_r <= adc_data;
		end
	end
	assign adc_start     = adc_go;
	assign adc_relative  = (mux_r == MUX_PH);
	assign adc_mux       = mux_r;
	assign amp_det_en    = (st_r == ST_MEAS || st_r == ST_CAL) && (mux_r == MUX_AMP);
	assign phase_det_en  = (st_r == ST_MEAS || st_r == ST_CAL) && (mux_r == MUX_PH);
	assign supply_div_en = (st_r == ST_MEAS) && (mux_r == MUX_SUP);
	assign supply_sel    = {ctrl_r[CTL_SUP_HI], ctrl_r[CTL_SUP_LO]};
	assign tx_force      = (st_r == ST_MEAS && mux_r != MUX_SUP) ||
		(st_r == ST_CAL) || (st_r == ST_REG);
	assign rx_force      = (st_r == ST_REG);

	// Calibration steps for drive and trim codes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive_r <= 8'h00;
			trim_r  <= 8'h00;
		end else if (st_r == ST_CAL && adc_got && !cal_hit) begin
			if (is_ant_r)
				trim_r <= cal_up ? trim_r - 8'h1 : trim_r + 8'h1;
			else
				drive_r <= cal_up ? drive_r + 8'h1 : drive_r - 8'h1;
		end
	end
	assign mod_drive           = drive_r;
	assign trim_capacitor_pins = trim_r;

	// Regulator setting walk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			regset_r <= 4'h0;
		else if (c_reg)
			regset_r <= reg_top;
		else if (st_r == ST_REG && reg_tick && !reg_done && !reg_to)
			regset_r <= regset_r - 4'h1;
	end
	assign reg_setting = regset_r;

	// Squelch and gain control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sqlg_r <= 4'h0;
			gain_r <= 4'h0;
		end else if (c_rgain) begin
			sqlg_r <= 4'h0;
			gain_r <= rxcf4_r;
		end else if (st_r == ST_SQL && sql_tick && noise_s && sqlg_r != 4'hf)
			sqlg_r <= sqlg_r + 4'h1;
	end
	assign squelch_run    = (st_r == ST_SQL);
	assign squelch_gain   = sqlg_r;
	assign gain_reduction = gain_r;

	// Receive masking
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_on_r   <= 1'b1;
			rx_on_d_r <= 1'b1;
		end else begin
			rx_on_d_r <= rx_on_r;
			rx_on_r   <= c_mask ? 1'b0 : (c_unmask ? 1'b1 : rx_on_r);
		end
	end
	assign rx_on          = rx_on_r;
	assign framing_en     = rx_on_r;
	assign mask_timer_clr = c_unmask && mtmr_s;

	// Peak-hold signal strength
	wire rssi_clr = (rx_on_r && !rx_on_d_r) || c_crssi;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rssi_r <= 6'h00;
		else if (rssi_clr)
			rssi_r <= 6'h00;
		else if (rx_on_r && rssi_level > rssi_r)
			rssi_r <= rssi_level;
	end

	// Transparent mode on slave select rise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ss_d_r  <= 1'b1;
			armed_r <= 1'b0;
			trsp_r  <= 1'b0;
		end else begin
			ss_d_r <= ss_s;
			armed_r <= c_trsp || (armed_r && !(ss_s && !ss_d_r));
			trsp_r  <= (armed_r && ss_s && !ss_d_r) || (trsp_r && ss_s);
		end
	end
	assign transparent = trsp_r;

	// Software registers and termination flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r      <= CTL_RST;
			mod_tgt_r   <= 8'h00;
			rxcf4_r     <= 4'h0;
			term_flag_r <= 1'b0;
		end else begin
			if (wr_ctrl)
				ctrl_r <= pwdata[7:0];
			if (wr_mod)
				mod_tgt_r <= pwdata[7:0];
			if (wr_rxcf4)
				rxcf4_r <= pwdata[3:0];
			if (term)
				term_flag_r <= 1'b1;
			else if (wr_stat && pwdata[STA_TERM])
				term_flag_r <= 1'b0;
		end
	end
	assign term_pulse = term;
endmodule : reader_direct_command_exec
`default_nettype wire

// file: reader_direct_command_exec_checker.sv
// Port-level assertions for the direct command executor
`timescale 1ns/1ps
`default_nettype none
module dcmd_checker
	import dcmd_pkg::*;
(
	// Clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// Watched pins
	input wire logic       ss_n,
	input wire logic       rx_on,
	input wire logic       framing_en,
	input wire logic       tx_force,
	input wire logic       amp_det_en,
	input wire logic       phase_det_en,
	input wire logic       supply_div_en,
	input wire logic       adc_relative,
	input wire logic [1:0] adc_mux,
	input wire logic [3:0] reg_setting,
	input wire logic       squelch_run,
	input wire logic       transparent,
	input wire logic       term_pulse
);
	localparam int MEAS_MAX = 505;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Any converter measurement starting
	sequence s_meas;
		$rose(amp_det_en || phase_det_en || supply_div_en);
	endsequence
	sequence s_done;
		##[0:MEAS_MAX] term_pulse;
	endsequence
	property p_frame; framing_en == rx_on; endproperty
	property p_amp; amp_det_en |-> tx_force && !adc_relative && adc_mux == MUX_AMP; endproperty
	property p_phase; phase_det_en |-> tx_force && adc_relative && adc_mux == MUX_PH; endproperty
	property p_sup; supply_div_en |-> !adc_relative && adc_mux == MUX_SUP; endproperty
	property p_meas; s_meas |-> s_done; endproperty
	property p_term; term_pulse |=> !term_pulse; endproperty
	property p_sql; squelch_run |-> !rx_on && !term_pulse; endproperty
	property p_reg;
		$changed(reg_setting) |-> reg_setting == $past(reg_setting) - 4'h1 ||
			reg_setting == REG5_TOP || reg_setting == REG3_TOP;
	endproperty
	property p_tr_on; $rose(transparent) |-> ss_n; endproperty
	property p_tr_off; $fell(ss_n) |-> ##[1:4] !transparent; endproperty
	a_frame: assert property (p_frame) else $error("framing enable differs");
	a_amp: assert property (p_amp) else $error("amplitude path wrong");
	a_phase: assert property (p_phase) else $error("phase path wrong");
	a_sup: assert property (p_sup) else $error("supply path wrong");
	a_meas: assert property (p_meas) else $error("measurement too long");
	a_term: assert property (p_term) else $error("termination pulse too long");
	a_sql: assert property (p_sql) else $error("squelch with rx on");
	a_reg: assert property (p_reg) else $error("regulator step wrong");
	a_tr_on: assert property (p_tr_on) else $error("transparent with select low");
	a_tr_off: assert property (p_tr_off) else $error("transparent kept");
endmodule : dcmd_checker
bind reader_direct_command_exec dcmd_checker i_dcmd_checker (.pclk, .presetn, .ss_n,
	.rx_on, .framing_en, .tx_force, .amp_det_en, .phase_det_en, .supply_div_en,
	.adc_relative, .adc_mux, .reg_setting, .squelch_run, .transparent, .term_pulse);
`default_nettype wire

// file: analog_side_model.sv
// Converter stand-in on the analog side of the executor
`timescale 1ns/1ps
`default_nettype none
module analog_side_model
	import dcmd_pkg::*;
(
	// Clock
	input  wire logic       pclk,
	// Converter control
	input  wire logic       adc_start,
	input  wire logic [1:0] adc_mux,
	input  wire logic [7:0] lat,
	// Converter answer
	output logic            adc_done,
	output logic [7:0]      adc_data
);
	int cnt = -1;
	initial adc_done = 1'b0;
	initial adc_data = 8'h00;
	// Answer lat+1 cycles after the start; data toggles outside the done pulse
	always @(posedge pclk) begin
		adc_done <= 1'b0;
		adc_data <= ~adc_data;
		if (adc_start)
			cnt <= lat;
		else if (cnt > 0)
			cnt <= cnt - 1;
		else if (cnt == 0) begin
			cnt <= -1;
			adc_done <= 1'b1;
			adc_data <= (adc_mux == MUX_AMP) ? 8'he6 : (adc_mux == MUX_PH) ? 8'h1f : 8'h8c;
		end
	end
endmodule : analog_side_model
`default_nettype wire

// file: reader_direct_command_exec_tb_top.sv
// Self-checking bench for the direct command executor
`timescale 1ns/1ps
`default_nettype none
module reader_direct_command_exec_tb_top
	import dcmd_pkg::*;
;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00, lat = 8'h03;
	logic [31:0] pwdata = 32'h0, q, prdata;
	logic        ss_n = 1'b1, osc_stable = 1'b1, reg_margin_ok = 1'b0, noise_detect = 1'b0;
	logic        mask_timer_running = 1'b0, err, pready, pslverr, adc_done, adc_start;
	logic [5:0]  rssi_level = 6'h00;
	logic        rx_on, framing_en, tx_force, rx_force, amp_det_en, phase_det_en;
	logic        supply_div_en, adc_relative, squelch_run, transparent, mask_timer_clr;
	logic        term_pulse;
	logic [1:0]  supply_sel, adc_mux;
	logic [3:0]  reg_setting, squelch_gain, gain_reduction;
	logic [7:0]  mod_drive, trim_capacitor_pins, adc_data;
	logic [7:0]  codes [3] = '{CMD_MEAS_AMP, CMD_MEAS_PH, CMD_MEAS_SUP};
	logic [7:0]  exps [3] = '{8'he6, 8'h1f, 8'h8c};
	int          error_cnt = 0, total_checks = 0, term_cnt = 0, clr_cnt = 0, cyc = 0, n;
	reader_direct_command_exec #(.SQL_CYC(40), .REGW_CYC(20),
		.MOD_CYC(60), .ANT_CYC(60), .SQLS_CYC(5)) i_reader_direct_command_exec (.pclk,
		.presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
		.ss_n, .osc_stable, .reg_margin_ok, .noise_detect, .mask_timer_running, .adc_done,
		.adc_data, .rssi_level, .rx_on, .framing_en, .tx_force, .rx_force, .amp_det_en,
		.phase_det_en, .supply_div_en, .supply_sel, .adc_start, .adc_relative, .adc_mux,
		.reg_setting, .squelch_run, .squelch_gain, .gain_reduction, .mod_drive,
		.trim_capacitor_pins, .transparent, .mask_timer_clr, .term_pulse);
	analog_side_model i_analog_side_model (.pclk, .adc_start, .adc_mux, .lat, .adc_done,
		.adc_data);
	// Clock, pulse counters and hang guard
	always #25 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (term_pulse === 1'b1)
			term_cnt++;
		if (mask_timer_clr === 1'b1)
			clr_cnt++;
		if (cyc == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end
	// One APB transfer; holds the request until pready is seen
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic cmd(input logic [7:0] c);
		apb(1'b1, OFF_CMD, {24'h0, c});
		repeat (3) @(posedge pclk);
	endtask : cmd
	task automatic wait_term(input int n0);
		for (int k = 0; k < 400 && term_cnt == n0; k++)
			@(posedge pclk);
		repeat (2) @(posedge pclk);
	endtask : wait_term
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic print_verdict;
		$display("Checks %0d, errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict
	// Main sequence
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFF_STAT, 32'h0);
		chk(q, 32'h2);
		cmd(CMD_MASK_RX);
		chk(rx_on, 1'b1);
		apb(1'b1, OFF_CTRL, 32'h1);
		cmd(CMD_MASK_RX);
		chk({rx_on, framing_en}, 2'b00);
		mask_timer_running <= 1'b1;
		cmd(CMD_UNMASK_RX);
		chk(rx_on, 1'b1);
		chk(clr_cnt, 1);
		chk(term_cnt, 0);
		$display("mask test done");
		apb(1'b1, OFF_CTRL, 32'h3);
		cmd(CMD_MEAS_AMP);
		chk(term_cnt, 0);
		osc_stable <= 1'b0;
		apb(1'b1, OFF_CTRL, 32'h83);
		cmd(CMD_MEAS_AMP);
		apb(1'b0, OFF_STAT, 32'h0);
		chk(q[STA_BUSY], 1'b0);
		chk(term_cnt, 0);
		osc_stable <= 1'b1;
		$display("gating test done");
		apb(1'b1, OFF_CTRL, 32'h9b);
		@(posedge pclk);
		chk(supply_sel, 2'b11);
		for (int s = 0; s < 2; s++) begin
			lat <= s ? 8'h28 : 8'h03;
			for (int i = 0; i < 3; i++) begin
				n = term_cnt;
				cmd(codes[i]);
				wait_term(n);
				chk(term_cnt, n + 1);
				apb(1'b0, OFF_ADC, 32'h0);
				chk(q, exps[i]);
				apb(1'b0, OFF_STAT, 32'h0);
				chk(q[STA_TERM], 1'b1);
				apb(1'b1, OFF_STAT, 32'h8);
			end
		end
		$display("measure test done");
		rssi_level <= 6'h15;
		apb(1'b0, OFF_RSSI, 32'h0);
		chk(q, 32'h15);
		rssi_level <= 6'h00;
		cmd(CMD_CLR_RSSI);
		apb(1'b0, OFF_RSSI, 32'h0);
		chk(q, 32'h0);
		apb(1'b1, OFF_RXCF4, 32'h5);
		n = term_cnt;
		cmd(CMD_SQUELCH);
		chk(squelch_run, 1'b0);
		cmd(CMD_MASK_RX);
		noise_detect <= 1'b1;
		cmd(CMD_SQUELCH);
		chk(squelch_run, 1'b1);
		repeat (12) @(posedge pclk);
		noise_detect <= 1'b0;
		repeat (8) @(posedge pclk);
		chk({squelch_run, squelch_gain === 4'h0}, 2'b00);
		cmd(CMD_RST_GAIN);
		chk({squelch_gain, gain_reduction}, 8'h05);
		noise_detect <= 1'b1;
		cmd(CMD_SQUELCH);
		cmd(CMD_RST_GAIN);
		chk({squelch_run, squelch_gain}, 5'h00);
		noise_detect <= 1'b0;
		chk(term_cnt, n);
		$display("gain test done");
		apb(1'b1, OFF_CTRL, 32'h9f);
		cmd(CMD_ADJ_REG);
		chk(rx_force, 1'b0);
		chk(term_cnt, n);
		apb(1'b1, OFF_CTRL, 32'h9b);
		cmd(CMD_ADJ_REG);
		chk({rx_force, tx_force, reg_setting}, {2'b11, REG5_TOP});
		wait_term(n);
		chk(reg_setting, 4'h0);
		apb(1'b1, OFF_CTRL, 32'hbb);
		reg_margin_ok <= 1'b1;
		n = term_cnt;
		cmd(CMD_ADJ_REG);
		wait_term(n);
		chk(reg_setting, REG3_TOP);
		$display("regulator test done");
		apb(1'b1, OFF_MOD, 32'h40);
		n = term_cnt;
		cmd(CMD_CAL_MOD);
		wait_term(n);
		chk(term_cnt, n + 1);
		apb(1'b0, OFF_MOD, 32'h0);
		chk(q[7:0], 8'h40);
		chk(q[15:8], 8'hff);
		cmd(CMD_CAL_ANT);
		wait_term(n + 1);
		apb(1'b0, OFF_STAT, 32'h0);
		chk(q[STA_BUSY], 1'b0);
		chk(trim_capacitor_pins, 8'hff);
		ss_n <= 1'b0;
		cmd(CMD_TRANSP);
		chk(transparent, 1'b0);
		ss_n <= 1'b1;
		repeat (8) @(posedge pclk);
		chk(transparent, 1'b1);
		ss_n <= 1'b0;
		repeat (8) @(posedge pclk);
		chk(transparent, 1'b0);
		apb(1'b0, 8'h40, 32'h0);
		chk(err, 1'b1);
		chk(q, 32'h0);
		$display("calibration and transparent test done");
		print_verdict();
	end
endmodule : reader_direct_command_exec_tb_top
`default_nettype wire
